/* File: irq_enable_prio.v */
// interrupt enable, priority registers and request start logic
`default_nettype none
`include "irq_defines.vh"
module irq_enable_prio (
  input  wire       clock_i,
  input  wire       sys_rst_i,
  input  wire       ce_i,
  // special-register port
  input  wire [7:0] reg_addr_i,
  input  wire       reg_wr_i,
  input  wire [7:0] reg_wdata_i,
  input  wire       bit_wr_i,
  input  wire [2:0] bit_sel_i,
  input  wire       bit_val_i,
  input  wire       page_i,
  output reg  [7:0] reg_rdata_o,
  // flags, already in the clock domain
  input  wire       adc_done_flag_i,
  input  wire       brownout_flag_i,
  input  wire       tx_done_flag_i,
  input  wire       rx_done_flag_i,
  input  wire       timer1_ovf_flag_i,
  input  wire       ext1_flag_i,
  input  wire       timer0_ovf_flag_i,
  input  wire       ext0_flag_i,
  input  wire       timer2_event_flag_i,
  input  wire       spi_xfer_flag_i,
  input  wire       spi_overrun_flag_i,
  input  wire       spi_mode_fault_flag_i,
  input  wire       brake_event_flag_i,
  input  wire       wdog_event_flag_i,
  input  wire       pwm_event_flag_i,
  input  wire [2:0] capture_flags_i,
  input  wire [7:0] pin_event_flags_i,
  input  wire       i2c_event_flag_i,
  input  wire       i2c_timeout_flag_i,
  input  wire       wakeup_tmr_flag_i,
  input  wire       timer3_ovf_flag_i,
  input  wire       tx1_done_flag_i,
  input  wire       rx1_done_flag_i,
  // core handshake
  input  wire       last_cycle_i,
  input  wire       blocking_instr_i,
  input  wire       return_i,
  input  wire       ack_taken_i,
  output wire [17:0] pending_o,
  output wire        start_o,
  output wire [4:0]  start_index_o,
  output wire [1:0]  start_level_o,
  output reg  [3:0]  active_levels_o
);
  // ==========================================================
  // registers
  reg [7:0] main_irq_enable;
  reg [7:0] ext_irq_enable_a;
  reg [7:0] ext_irq_enable_b;
  reg [7:0] main_prio_low;
  reg [7:0] main_prio_high;

  // high priority only visible on page zero
  function hit;
    input [7:0] addr;
    input [7:0] target;
    input       page;
    begin
      hit = (addr == target) && ((target != `ADDR_PRIO_HIGH) || (page == `PAGE_ZERO));
    end
  endfunction

  function [7:0] merged;
    input [7:0] old;
    begin
      merged = old;
      if (bit_wr_i)
        merged[bit_sel_i] = bit_val_i;
      else
        merged = reg_wdata_i;
    end
  endfunction

  wire wr_any = reg_wr_i | bit_wr_i;

  always @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      main_irq_enable  <= `REG_RESET;
      ext_irq_enable_a <= `REG_RESET;
      ext_irq_enable_b <= `REG_RESET;
      main_prio_low    <= `REG_RESET;
      main_prio_high   <= `REG_RESET;
    end
    else if (ce_i && wr_any)
    begin
      if (hit(reg_addr_i, `ADDR_MAIN_ENABLE, page_i))
        main_irq_enable <= merged(main_irq_enable);
      if (hit(reg_addr_i, `ADDR_EXT_ENABLE_A, page_i))
        ext_irq_enable_a <= merged(ext_irq_enable_a);
      if (hit(reg_addr_i, `ADDR_EXT_ENABLE_B, page_i))
        ext_irq_enable_b <= merged(ext_irq_enable_b) & `MASK_EXT_B;
      if (hit(reg_addr_i, `ADDR_PRIO_LOW, page_i))
        main_prio_low <= merged(main_prio_low) & `MASK_PRIO;
      if (hit(reg_addr_i, `ADDR_PRIO_HIGH, page_i))
        main_prio_high <= merged(main_prio_high) & `MASK_PRIO;
    end
  end

  // read data registered; unmapped reads zero
  always @(posedge clock_i)
  begin
    if (sys_rst_i)
      reg_rdata_o <= 8'h00;
    else if (ce_i)
    begin
      if (hit(reg_addr_i, `ADDR_MAIN_ENABLE, page_i))
        reg_rdata_o <= main_irq_enable;
      else if (hit(reg_addr_i, `ADDR_EXT_ENABLE_A, page_i))
        reg_rdata_o <= ext_irq_enable_a;
      else if (hit(reg_addr_i, `ADDR_EXT_ENABLE_B, page_i))
        reg_rdata_o <= ext_irq_enable_b;
      else if (hit(reg_addr_i, `ADDR_PRIO_LOW, page_i))
        reg_rdata_o <= main_prio_low;
      else if (hit(reg_addr_i, `ADDR_PRIO_HIGH, page_i))
        reg_rdata_o <= main_prio_high;
      else
        reg_rdata_o <= 8'h00;
    end
  end

  // ==========================================================
  // source gating
  wire        global_irq_gate   = main_irq_enable[`BIT_GLOBAL];
  wire        adc_irq_on        = main_irq_enable[`BIT_ADC];
  wire        brownout_irq_on   = main_irq_enable[`BIT_BROWNOUT];
  wire        serial0_irq_on    = main_irq_enable[`BIT_SERIAL0];
  wire        timer1_irq_on     = main_irq_enable[`BIT_TIMER1];
  wire        extline1_irq_on   = main_irq_enable[`BIT_EXTLINE1];
  wire        timer0_irq_on     = main_irq_enable[`BIT_TIMER0];
  wire        extline0_irq_on   = main_irq_enable[`BIT_EXTLINE0];
  wire        timer2_irq_on     = ext_irq_enable_a[`BIT_TIMER2];
  wire        spi_irq_on        = ext_irq_enable_a[`BIT_SPI];
  wire        brake_irq_on      = ext_irq_enable_a[`BIT_BRAKE];
  wire        wdog_irq_on       = ext_irq_enable_a[`BIT_WDOG];
  wire        pwm_irq_on        = ext_irq_enable_a[`BIT_PWM];
  wire        capture_irq_on    = ext_irq_enable_a[`BIT_CAPTURE];
  wire        pin_irq_on        = ext_irq_enable_a[`BIT_PIN];
  wire        i2c_irq_on        = ext_irq_enable_a[`BIT_I2C];
  wire        wakeup_tmr_irq_on = ext_irq_enable_b[`BIT_WAKEUP];
  wire        timer3_irq_on     = ext_irq_enable_b[`BIT_TIMER3];
  wire        serial1_irq_on    = ext_irq_enable_b[`BIT_SERIAL1];
  wire [17:0] src_flag;
  wire [17:0] src_en;
  assign src_flag = {
    tx1_done_flag_i | rx1_done_flag_i,
    timer3_ovf_flag_i,
    wakeup_tmr_flag_i,
    i2c_event_flag_i | i2c_timeout_flag_i,
    |pin_event_flags_i,
    |capture_flags_i,
    pwm_event_flag_i,
    wdog_event_flag_i,
    brake_event_flag_i,
    spi_xfer_flag_i | spi_overrun_flag_i | spi_mode_fault_flag_i,
    timer2_event_flag_i,
    adc_done_flag_i,
    brownout_flag_i,
    tx_done_flag_i | rx_done_flag_i,
    timer1_ovf_flag_i,
    ext1_flag_i,
    timer0_ovf_flag_i,
    ext0_flag_i
  };
  // same order as src_flag: serial 1 on top, external line 0 at the bottom
  assign src_en = {serial1_irq_on, timer3_irq_on, wakeup_tmr_irq_on, i2c_irq_on, pin_irq_on, capture_irq_on,
                   pwm_irq_on, wdog_irq_on, brake_irq_on, spi_irq_on, timer2_irq_on,
                   adc_irq_on, brownout_irq_on, serial0_irq_on, timer1_irq_on, extline1_irq_on,
                   timer0_irq_on, extline0_irq_on};

  genvar g;
  generate
    for (g = 0; g < `NUM_SRC; g = g + 1)
    begin : gate_gen
      // combinational so a flag that drops is never remembered
      irq_gate u_gate (
        .flag_i    (src_flag[g]),
        .enable_i  (src_en[g]),
        .global_i  (global_irq_gate),
        .pending_o (pending_o[g])
      );
    end
  endgenerate

  // levels: extended sources have no priority storage here, so level 00
  wire [35:0] level;
  generate
    for (g = 0; g < `NUM_SRC; g = g + 1)
    begin : level_gen
      if (g < 7)
      begin : main_lv
        assign level[2*g +: 2] = {main_prio_high[g], main_prio_low[g]};
      end
      else
      begin : ext_lv
        assign level[2*g +: 2] = 2'b00;
      end
    end
  endgenerate

  wire       any_pending;
  wire [1:0] best_level;
  irq_prio_pick u_pick (
    .pending_i    (pending_o),
    .level_i      (level),
    .any_o        (any_pending),
    .best_level_o (best_level),
    .best_index_o (start_index_o)
  );
  assign start_level_o = best_level;

  // ==========================================================
  // start decision and in-service tracking
  reg        busy_higher;
  reg [1:0]  top_level;
  integer    k;
  always @*
  begin
    busy_higher = 1'b0;
    top_level   = 2'b00;
    for (k = 0; k < 4; k = k + 1)
    begin
      if (active_levels_o[k])
      begin
        busy_higher = 1'b1;
        top_level   = k[1:0];
      end
    end
  end

  assign start_o = ce_i & any_pending & last_cycle_i & ~blocking_instr_i & ~return_i & ~wr_any &
                   (~busy_higher | (best_level > top_level));

  always @(posedge clock_i)
  begin
    if (sys_rst_i)
      active_levels_o <= 4'h0;
    else if (ce_i)
    begin
      if (ack_taken_i && start_o)
        active_levels_o[best_level] <= 1'b1;
      else if (return_i && last_cycle_i && busy_higher)
        active_levels_o[top_level] <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: irq_defines.vh */
// constants for the interrupt enable and priority block
`ifndef IRQ_DEFINES_VH
`define IRQ_DEFINES_VH
`define ADDR_EXT_ENABLE_A 8'h9b
`define ADDR_EXT_ENABLE_B 8'h9c
`define ADDR_MAIN_ENABLE  8'ha8
`define ADDR_PRIO_HIGH    8'hb7
`define ADDR_PRIO_LOW     8'hb8
`define REG_RESET         8'h00
`define MASK_EXT_B        8'h07
`define MASK_PRIO         8'h7f
`define BIT_GLOBAL        7
`define BIT_ADC           6
`define BIT_BROWNOUT      5
`define BIT_SERIAL0       4
`define BIT_TIMER1        3
`define BIT_EXTLINE1      2
`define BIT_TIMER0        1
`define BIT_EXTLINE0      0
`define BIT_TIMER2        7
`define BIT_SPI           6
`define BIT_BRAKE         5
`define BIT_WDOG          4
`define BIT_PWM           3
`define BIT_CAPTURE       2
`define BIT_PIN           1
`define BIT_I2C           0
`define BIT_WAKEUP        2
`define BIT_TIMER3        1
`define BIT_SERIAL1       0
`define NUM_SRC           18
`define PAGE_ZERO         1'b0
`endif

/* File: irq_gate.v */
// one source gate: flag with own and global enable
`default_nettype none
module irq_gate (
  input  wire flag_i,
  input  wire enable_i,
  input  wire global_i,
  output wire pending_o
);
  assign pending_o = flag_i & enable_i & global_i;
endmodule
`default_nettype wire

/* File: irq_prio_pick.v */
// picks the highest pending level and lowest index source
`default_nettype none
`include "irq_defines.vh"
module irq_prio_pick (
  input  wire [17:0] pending_i,
  input  wire [35:0] level_i,
  output reg         any_o,
  output reg  [1:0]  best_level_o,
  output reg  [4:0]  best_index_o
);
  integer i;
  always @*
  begin
    any_o        = 1'b0;
    best_level_o = 2'b00;
    best_index_o = 5'h00;
    for (i = `NUM_SRC - 1; i >= 0; i = i - 1)
    begin
      // lower index wins ties since it is visited last
      if (pending_i[i] && (!any_o || level_i[2*i +: 2] >= best_level_o))
      begin
        any_o        = 1'b1;
        best_level_o = level_i[2*i +: 2];
        best_index_o = i[4:0];
      end
    end
  end
endmodule
`default_nettype wire

/* File: irq_enable_prio_props.sv */
// port-level assertions for the interrupt enable and priority block
`default_nettype none
module irq_enable_prio_props (
  input wire logic        clock_i,
  input wire logic        sys_rst_i,
  input wire logic        ce_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        bit_wr_i,
  input wire logic        page_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        last_cycle_i,
  input wire logic        blocking_instr_i,
  input wire logic        return_i,
  input wire logic [17:0] pending_o,
  input wire logic        start_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // request start and register read-back
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  a_start_last_only: assert property (!last_cycle_i |-> !start_o) else $error("start outside last cycle");
  a_start_blocked: assert property (blocking_instr_i || return_i || reg_wr_i || bit_wr_i |-> !start_o)
    else $error("start during a blocking cycle");
  a_start_has_pending: assert property (start_o |-> pending_o != 18'h00000) else $error("start with nothing");
  a_main_readback: assert property (ce_i && reg_wr_i && !bit_wr_i && reg_addr_i == 8'ha8 ##1
    ce_i && reg_addr_i == 8'ha8 && !reg_wr_i && !bit_wr_i |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("main enable read-back differs");
  a_high_page_hidden: assert property (ce_i && reg_addr_i == 8'hb7 && page_i |=> reg_rdata_o == 8'h00)
    else $error("high priority visible off page 0");
  a_low_bit7_zero: assert property (ce_i && reg_addr_i == 8'hb8 |=> !reg_rdata_o[7])
    else $error("low priority bit 7 set");
  a_extb_top_zero: assert property (ce_i && reg_addr_i == 8'h9c |=> reg_rdata_o[7:3] == 5'h00)
    else $error("extended-b unused bits set");
  a_unmapped_zero: assert property (ce_i && reg_addr_i == 8'h00 |=> reg_rdata_o == 8'h00)
    else $error("unmapped address reads nonzero");
  a_ce_freeze_rdata: assert property (!ce_i |=> $stable(reg_rdata_o))
    else $error("read data moved while clock enable low");
  a_ce_blocks_start: assert property (!ce_i |-> !start_o) else $error("start while clock enable low");
endmodule
bind irq_enable_prio irq_enable_prio_props u_props (.*);
`default_nettype wire

/* File: irq_core_model.sv */
// cpu core side model: instruction end timing and acceptance
`default_nettype none
module irq_core_model (
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  input  wire logic slow_i,
  input  wire logic accept_i,
  input  wire logic start_i,
  output logic      last_cycle_o,
  output logic      ack_taken_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] phase;
  // slow mode ends an instruction only every fourth cycle
  always @(posedge clock_i)
    phase <= sys_rst_i ? 2'h0 : phase + 2'h1;
  assign last_cycle_o = !slow_i || phase == 2'h3;
  assign ack_taken_o  = accept_i && start_i;
endmodule
`default_nettype wire

/* File: interrupt_enable_priority_bench.sv */
// self-checking bench for the interrupt enable and priority block
`default_nettype none
module interrupt_enable_priority_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock_i = 0;
  logic        sys_rst_i = 1;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 0;
  logic        bwr = 0;
  logic [2:0]  bsel = 3'h0;
  logic        bval = 0;
  logic        page = 0;
  logic [31:0] fv = 32'h0;
  logic        blk = 0;
  logic        ret = 0;
  logic        slow = 0;
  logic        accept = 0;
  logic        ce = 1;
  logic [7:0]  m, a, b;
  logic [7:0]  regs [6] = '{8'ha8, 8'h9b, 8'h9c, 8'hb8, 8'hb7, 8'h00};
  logic [7:0]  wexp [6] = '{8'hff, 8'hff, 8'h07, 8'h7f, 8'h7f, 8'h00};
  logic [7:0]  pm [4] = '{8'hff, 8'hd5, 8'haa, 8'h7f};
  logic [7:0]  pa [4] = '{8'hff, 8'h5a, 8'ha5, 8'hff};
  logic [7:0]  pb [4] = '{8'h07, 8'h01, 8'h06, 8'h07};
  wire  [7:0]  rdata;
  wire  [17:0] pend;
  wire  [4:0]  sidx;
  wire  [1:0]  slvl;
  wire  [3:0]  act;
  wire         start, last, ack;
  int          failures = 0;
  int          n_tests = 0;
  irq_enable_prio dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .bit_wr_i(bwr), .bit_sel_i(bsel), .bit_val_i(bval), .page_i(page), .reg_rdata_o(rdata),
    .ext0_flag_i(fv[0]), .timer0_ovf_flag_i(fv[1]), .ext1_flag_i(fv[2]), .timer1_ovf_flag_i(fv[3]),
    .tx_done_flag_i(fv[4]), .rx_done_flag_i(fv[5]), .brownout_flag_i(fv[6]), .adc_done_flag_i(fv[7]),
    .timer2_event_flag_i(fv[8]), .spi_xfer_flag_i(fv[9]), .spi_overrun_flag_i(fv[10]), .spi_mode_fault_flag_i(fv[11]),
    .brake_event_flag_i(fv[12]), .wdog_event_flag_i(fv[13]), .pwm_event_flag_i(fv[14]), .capture_flags_i(fv[17:15]),
    .pin_event_flags_i(fv[25:18]), .i2c_event_flag_i(fv[26]), .i2c_timeout_flag_i(fv[27]), .wakeup_tmr_flag_i(fv[28]),
    .timer3_ovf_flag_i(fv[29]), .tx1_done_flag_i(fv[30]), .rx1_done_flag_i(fv[31]), .last_cycle_i(last),
    .blocking_instr_i(blk), .return_i(ret), .ack_taken_i(ack), .pending_o(pend), .start_o(start),
    .start_index_o(sidx), .start_level_o(slvl), .active_levels_o(act));
  irq_core_model core (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .slow_i(slow), .accept_i(accept), .start_i(start),
    .last_cycle_o(last), .ack_taken_o(ack));
  // ==========================================
  // access and compare tasks
  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr8(input logic [7:0] ad, input logic [7:0] d);
    @(negedge clock_i);
    addr = ad;
    wdata = d;
    wr = 1;
    @(negedge clock_i);
    wr = 0;
  endtask
  task automatic rd8(input logic [7:0] ad, input logic [7:0] exp);
    @(negedge clock_i);
    addr = ad;
    @(negedge clock_i);
    check(rdata, exp);
  endtask
  task automatic set_en(input logic [7:0] mm, input logic [7:0] aa, input logic [7:0] bb);
    m = mm;
    a = aa;
    b = bb;
    wr8(8'ha8, mm);
    wr8(8'h9b, aa);
    wr8(8'h9c, bb);
  endtask
  // shared sources fold their flags before the enable gate
  function automatic logic [17:0] exp_pend();
    logic [17:0] src;
    src = {fv[31] | fv[30], fv[29], fv[28], |fv[27:26], |fv[25:18], |fv[17:15], fv[14:12], |fv[11:9], fv[8:6],
           fv[5] | fv[4], fv[3:0]};
    return src & {b[0], b[1], b[2], a[0], a[1], a[2], a[3], a[4], a[5], a[6], a[7], m[6:0]} & {18{m[7]}};
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ==========================================
  // clock, watchdog and test sequence
  initial
    forever #50 clock_i = ~clock_i;
  initial
  begin
    repeat (3000) @(posedge clock_i);
    failures++;
    final_report();
  end
  initial
  begin
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
    sys_rst_i = 0;
    foreach (regs[i]) rd8(regs[i], 8'h00);
    foreach (regs[i])
    begin
      wr8(regs[i], 8'hff);
      rd8(regs[i], wexp[i]);
    end
    page = 1;
    wr8(8'hb7, 8'h00);
    rd8(8'hb7, 8'h00);
    page = 0;
    rd8(8'hb7, 8'h7f);
    $display("test registers done");
    for (int p = 0; p < 4; p++)
    begin
      set_en(pm[p], pa[p], pb[p]);
      for (int i = 0; i < 33; i++)
      begin
        @(negedge clock_i);
        fv = (i == 32) ? 32'hffffffff : 32'h1 << i;
        #1 check(pend, exp_pend());
      end
    end
    $display("test gating done");
    set_en(8'h83, 8'h00, 8'h00);
    wr8(8'hb8, 8'h01);
    wr8(8'hb7, 8'h02);
    fv = 32'h3;
    #1 check({start, sidx, slvl}, {1'b1, 5'h01, 2'h2});
    blk = 1;
    #1 check(start, 1'b0);
    blk = 0;
    ret = 1;
    #1 check(start, 1'b0);
    ret = 0;
    slow = 1;
    repeat (8) @(negedge clock_i) check(start, last);
    slow = 0;
    accept = 1;
    @(negedge clock_i);
    accept = 0;
    check({act, start}, {4'h4, 1'b0});
    wr8(8'hb7, 8'h03);
    #1 check({start, sidx, slvl}, {1'b1, 5'h00, 2'h3});
    ret = 1;
    @(negedge clock_i);
    ret = 0;
    check(act, 4'h0);
    addr = 8'ha8;
    bsel = 3'h7;
    bval = 0;
    bwr = 1;
    @(negedge clock_i);
    bwr = 0;
    #1 check(pend, 18'h00000);
    rd8(8'ha8, 8'h03);
    // clock enable low: the write is dropped and the read data holds
    ce = 0;
    wr8(8'h9b, 8'h55);
    check(rdata, 8'h03);
    ce = 1;
    rd8(8'h9b, 8'h00);
    $display("test start done");
    final_report();
  end
endmodule
`default_nettype wire
